/* emr_pkg.sv */
// package for the execution-mode, reset and watchdog controller
// assumes one core clock; all pin inputs arrive synchronous to it
// What this block does
// - four sources force reset mode
// - reset output held 1024 system clocks minimum
// - status records cause of last reset
// - run mode executes and peripherals run
// - halt input freezes units, stops timers
// - power-down write freezes integer/float units
// - any external interrupt ends power-down
// - parity error or unit error mode halts
// - error halt left only by cold reset
// - error output shows any unmasked error
// - unit errors latched into status register
// - latched error halts processor by default
// - parity checked on address, type, data buses
// - disable input suppresses external parity checks
// - system clock is input divided by two
// - software availability bit drives availability output
// - internal watchdog runs only when enabled
// - watchdog counts on its own clock input
// - after reset watchdog restarts from maximum
// - zero count raises interrupt, starts time-out
// - unacknowledged time-out resets the device
// - watchdog interrupt cannot be masked
package emr_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_SOFT_RST = 8'h08;
    localparam logic [7:0] ADDR_PWR_DOWN = 8'h0C;
    localparam logic [7:0] ADDR_DOG_LOAD = 8'h10;
    localparam logic [7:0] ADDR_DOG_ACK = 8'h14;
    localparam logic [7:0] ADDR_DOG_CNT = 8'h18;
    // error latch order: iu, fpu, parity, iu error mode
    localparam int ERR_N = 4;
    localparam int ST_ERR_LSB = 3;
    localparam int ST_AVAIL = 7;
    localparam int ST_MODE_LSB = 8;
    localparam int CT_HALT_EN = 4;
    localparam int CT_PAR_RST = 5;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic HALT_EN_RST = 1'b1;
    localparam logic [2:0] CAUSE_NONE = 3'h0;
    localparam logic [2:0] CAUSE_COLD = 3'h1;
    localparam logic [2:0] CAUSE_SOFT = 3'h2;
    localparam logic [2:0] CAUSE_DOG = 3'h3;
    localparam logic [2:0] CAUSE_PAR = 3'h4;
    localparam int DOG_W = 16;
    localparam logic [15:0] DOG_MAX = 16'hFFFF;
    localparam logic [7:0] DOG_RST_TIMEOUT = 8'hFF;
    localparam logic [10:0] RST_HOLD_CORE_CLOCK_OUT = 11'h400;
    typedef enum logic [2:0] {
        EMR_MODE_RESET = 3'b000,
        EMR_MODE_RUN = 3'b001,
        EMR_MODE_SYS_HALT = 3'b010,
        EMR_MODE_PWR_DOWN = 3'b011,
        EMR_MODE_ERR_HALT = 3'b100
    } emr_mode_e;
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic addr_par;
        logic [3:0] asi;
        logic [1:0] size;
        logic asi_par;
        logic [31:0] data;
        logic data_par;
    } emr_bus_chk_s;
    typedef struct packed {
        logic iu_err;
        logic fpu_err;
        logic ctrl_par_err;
        logic iu_err_mode;
    } emr_err_in_s;
endpackage : emr_pkg

/* emr_ctrl.sv */
// execution-mode controller: reset sequencing, halts, error latching,
// parity checking, system clock divider and internal watchdog
// assumes all inputs synchronous to i_core_clk; the watchdog clock pin
// is sampled and edge-detected, so it must run below half the core rate
`timescale 1ns/100ps
module emr_ctrl
    import emr_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_cold_reset_in,
    input wire logic i_halt_request_in,
    input wire logic i_parity_check_disable_in,
    input wire logic i_internal_dog_enable_in,
    input wire logic i_dog_clock_in,
    input wire logic [4:0] i_ext_int,
    input wire emr_err_in_s i_err,
    input wire emr_bus_chk_s i_bus,
    input wire logic [31:0] i_data_out,
    output logic o_data_par_out,
    output logic o_reset_out,
    output logic o_unit_freeze,
    output logic o_unit_run,
    output logic o_timer_run,
    output logic o_error_flag_out,
    output logic o_availability_flag,
    output logic o_core_clock_out,
    output logic o_dog_irq,
    output logic [2:0] o_mode
);
    emr_mode_e mode_r;
    emr_mode_e mode_nxt;
    logic [2:0] cause_r;
    logic [ERR_N-1:0] err_lat_r;
    logic [ERR_N-1:0] err_evt;
    logic [ERR_N-1:0] err_mask_r;
    logic halt_en_r;
    logic par_rst_r;
    logic [10:0] rst_cnt_r;
    logic [DOG_W-1:0] dog_cnt_r;
    logic [7:0] dog_tmo_r;
    logic dog_tmo_act_r;
    logic dog_prev_r;
    logic dog_tick;
    logic dog_run;
    logic dog_start;
    logic dog_expire;
    logic sys_tick;
    logic ext_par_err;
    logic wr_status;
    logic wr_soft;
    logic wr_pwr;
    logic wr_load;
    logic wr_ack;
    logic par_rst_trig;
    logic reset_trig;
    logic halt_err;

    // register strobes
    assign wr_status = i_wr && (i_addr == ADDR_STATUS);
    assign wr_soft = i_wr && (i_addr == ADDR_SOFT_RST);
    assign wr_pwr = i_wr && (i_addr == ADDR_PWR_DOWN);
    assign wr_load = i_wr && (i_addr == ADDR_DOG_LOAD);
    assign wr_ack = i_wr && (i_addr == ADDR_DOG_ACK);

    // odd parity on each external group; internal control bus is never suppressed
    assign ext_par_err = i_bus.valid && !i_parity_check_disable_in &&
        (!(^{i_bus.addr, i_bus.addr_par}) || !(^{i_bus.asi, i_bus.size, i_bus.asi_par})
        || !(^{i_bus.data, i_bus.data_par}));
    assign err_evt = {i_err.iu_err_mode, ext_par_err | i_err.ctrl_par_err,
        i_err.fpu_err, i_err.iu_err};

    // parity error either resets or halts, selected by software
    assign par_rst_trig = err_evt[2] && !err_mask_r[2] && par_rst_r;
    assign reset_trig = i_cold_reset_in || wr_soft || dog_expire || par_rst_trig;
    assign halt_err = (|(err_lat_r[1:0] & ~err_mask_r[1:0]) && halt_en_r)
        || (err_lat_r[2] && !err_mask_r[2] && !par_rst_r)
        || (err_lat_r[3] && !err_mask_r[3]);

    // mode sequencing; error halt ignores every source except cold reset
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            EMR_MODE_RESET: begin
                if (i_cold_reset_in || wr_soft || dog_expire || par_rst_trig) begin
                    mode_nxt = EMR_MODE_RESET;
                end else if (rst_cnt_r == RST_HOLD_CORE_CLOCK_OUT) begin
                    mode_nxt = EMR_MODE_RUN;
                end
            end
            EMR_MODE_ERR_HALT: begin
                if (i_cold_reset_in) begin
                    mode_nxt = EMR_MODE_RESET;
                end
            end
            EMR_MODE_RUN, EMR_MODE_SYS_HALT, EMR_MODE_PWR_DOWN: begin
                if (reset_trig) begin
                    mode_nxt = EMR_MODE_RESET;
                end else if (halt_err) begin
                    mode_nxt = EMR_MODE_ERR_HALT;
                end else if (i_halt_request_in) begin
                    mode_nxt = EMR_MODE_SYS_HALT;
                end else if (mode_r == EMR_MODE_PWR_DOWN) begin
                    if (|i_ext_int) begin
                        mode_nxt = EMR_MODE_RUN;
                    end
                end else if (wr_pwr) begin
                    mode_nxt = EMR_MODE_PWR_DOWN;
                end else begin
                    mode_nxt = EMR_MODE_RUN;
                end
            end
            default: begin
                mode_nxt = EMR_MODE_RESET;
            end
        endcase
    end

    // mode register and the mode-decoded outputs, registered from the next mode
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            mode_r <= EMR_MODE_RESET;
            o_mode <= EMR_MODE_RESET;
            o_reset_out <= 1'b1;
            o_unit_freeze <= 1'b1;
            o_unit_run <= 1'b0;
            o_timer_run <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            o_mode <= mode_nxt;
            o_reset_out <= (mode_nxt == EMR_MODE_RESET);
            o_unit_freeze <= (mode_nxt != EMR_MODE_RUN);
            o_unit_run <= (mode_nxt == EMR_MODE_RUN);
            // timers keep running in power-down; halt and error halt stop them
            o_timer_run <= (mode_nxt == EMR_MODE_RUN) ||
                (mode_nxt == EMR_MODE_PWR_DOWN);
        end
    end

    // divide by two; sys_tick marks the core edge where the system clock rises
    assign sys_tick = !o_core_clock_out;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_core_clock_out <= 1'b0;
        end else begin
            o_core_clock_out <= !o_core_clock_out;
        end
    end

    // reset stretch counted in system clocks; restarts on every new trigger
    always_ff @(posedge i_core_clk) begin
        if (i_rst || mode_r != EMR_MODE_RESET || reset_trig) begin
            rst_cnt_r <= 11'h000;
        end else if (sys_tick && rst_cnt_r != RST_HOLD_CORE_CLOCK_OUT) begin
            rst_cnt_r <= rst_cnt_r + 11'h001;
        end
    end

    // last reset cause; cold wins over the rest when several coincide
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cause_r <= CAUSE_COLD;
        end else if (i_cold_reset_in) begin
            cause_r <= CAUSE_COLD;
        end else if (mode_r != EMR_MODE_ERR_HALT) begin
            if (dog_expire) begin
                cause_r <= CAUSE_DOG;
            end else if (wr_soft) begin
                cause_r <= CAUSE_SOFT;
            end else if (par_rst_trig) begin
                cause_r <= CAUSE_PAR;
            end
        end
    end

    // error latches: write one to clear, a new error in the same cycle wins
    generate
        for (genvar g = 0; g < ERR_N; g++) begin : g_err
            always_ff @(posedge i_core_clk) begin
                if (i_rst || i_cold_reset_in) begin
                    err_lat_r[g] <= 1'b0;
                end else if (err_evt[g]) begin
                    err_lat_r[g] <= 1'b1;
                end else if (wr_status && i_wdata[ST_ERR_LSB+g]) begin
                    err_lat_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // error output reflects latched errors not masked off
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_error_flag_out <= 1'b0;
        end else begin
            o_error_flag_out <= |(err_lat_r & ~err_mask_r);
        end
    end

    // control and availability registers
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            err_mask_r <= MASK_RST;
            halt_en_r <= HALT_EN_RST;
            par_rst_r <= 1'b0;
            o_availability_flag <= 1'b0;
        end else begin
            if (i_wr && i_addr == ADDR_CTRL) begin
                err_mask_r <= i_wdata[ERR_N-1:0];
                halt_en_r <= i_wdata[CT_HALT_EN];
                par_rst_r <= i_wdata[CT_PAR_RST];
            end
            if (wr_status) begin
                o_availability_flag <= i_wdata[ST_AVAIL];
            end
        end
    end

    // watchdog: ticks on rising edges of its own clock pin
    assign dog_tick = i_dog_clock_in && !dog_prev_r;
    assign dog_run = i_internal_dog_enable_in && dog_tick &&
        (mode_r == EMR_MODE_RUN || mode_r == EMR_MODE_PWR_DOWN);
    assign dog_start = dog_run && !dog_tmo_act_r && (dog_cnt_r == 16'h0001) &&
        !wr_load;
    assign dog_expire = dog_run && dog_tmo_act_r && (dog_tmo_r == 8'h01) &&
        !wr_load && !wr_ack;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            dog_prev_r <= 1'b0;
        end else begin
            dog_prev_r <= i_dog_clock_in;
        end
    end

    // a reload clears a pending time-out; an acknowledge only stops the time-out
    always_ff @(posedge i_core_clk) begin
        if (i_rst || mode_r == EMR_MODE_RESET) begin
            dog_cnt_r <= DOG_MAX;
            dog_tmo_r <= DOG_RST_TIMEOUT;
            dog_tmo_act_r <= 1'b0;
        end else if (wr_load) begin
            dog_cnt_r <= i_wdata[DOG_W-1:0];
            dog_tmo_r <= DOG_RST_TIMEOUT;
            dog_tmo_act_r <= 1'b0;
        end else if (wr_ack) begin
            dog_tmo_r <= DOG_RST_TIMEOUT;
            dog_tmo_act_r <= 1'b0;
        end else if (dog_run) begin
            if (dog_cnt_r != 16'h0000) begin
                dog_cnt_r <= dog_cnt_r - 16'h0001;
            end
            if (dog_start) begin
                dog_tmo_act_r <= 1'b1;
            end else if (dog_tmo_act_r && dog_tmo_r != 8'h00) begin
                dog_tmo_r <= dog_tmo_r - 8'h01;
            end
        end
    end

    // the time-out interrupt bypasses every mask
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_dog_irq <= 1'b0;
        end else begin
            o_dog_irq <= dog_start;
        end
    end

    // parity generated for outgoing data, odd like the check
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_data_par_out <= 1'b0;
        end else begin
            o_data_par_out <= ~^i_data_out;
        end
    end

    // read port: data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !i_rd) begin
            o_rdata <= 32'h0000_0000;
        end else begin
            unique case (i_addr)
                ADDR_STATUS: o_rdata <= {21'h00_0000, mode_r,
                    o_availability_flag, err_lat_r, cause_r};
                ADDR_CTRL: o_rdata <= {26'h000_0000, par_rst_r, halt_en_r, err_mask_r};
                ADDR_DOG_CNT: o_rdata <= {7'h00, dog_tmo_act_r, dog_tmo_r, dog_cnt_r};
                default: o_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic [11:0] rst_len_r;
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !o_reset_out) begin
            rst_len_r <= 12'h000;
        end else if (rst_len_r != 12'hFFF) begin
            rst_len_r <= rst_len_r + 12'h001;
        end
    end

    chk_reset_stretch_len: assert property ($fell(o_reset_out) |-> rst_len_r >= 12'h800)
        else $error("reset output released too early");
    chk_soft_reset_enter: assert property (
        wr_soft && mode_r != EMR_MODE_ERR_HALT |=> o_reset_out && mode_r == EMR_MODE_RESET)
        else $error("software reset did not enter reset mode");
    chk_cause_soft_kept: assert property (
        wr_soft && !i_cold_reset_in && !dog_expire && mode_r != EMR_MODE_ERR_HALT
        |=> cause_r == CAUSE_SOFT)
        else $error("software reset cause not recorded");
    chk_halt_freeze_out: assert property (
        mode_r == EMR_MODE_SYS_HALT |-> o_unit_freeze && !o_timer_run && !dog_run)
        else $error("system halt left units or timers running");
    chk_err_halt_sticky: assert property (
        mode_r == EMR_MODE_ERR_HALT && !i_cold_reset_in |=> mode_r == EMR_MODE_ERR_HALT)
        else $error("error halt left without cold reset");
    chk_pwr_wake_int: assert property (
        mode_r == EMR_MODE_PWR_DOWN && |i_ext_int && !reset_trig && !halt_err
        && !i_halt_request_in |=> o_unit_run)
        else $error("external interrupt did not end power-down");
    chk_err_flag_raise: assert property (
        i_err.fpu_err && !err_mask_r[1] && !(i_wr && i_addr == ADDR_CTRL)
        |-> ##[1:2] o_error_flag_out)
        else $error("unmasked error not flagged");
    chk_clock_half_rate: assert property (
        o_core_clock_out |=> !o_core_clock_out ##1 o_core_clock_out)
        else $error("system clock not divided by two");
    chk_avail_follow: assert property (
        wr_status |=> o_availability_flag == $past(i_wdata[ST_AVAIL]))
        else $error("availability output not updated");
    chk_dog_irq_pulse: assert property (dog_start |=> o_dog_irq ##1 !o_dog_irq)
        else $error("watchdog interrupt not raised once");
    chk_dog_off_quiet: assert property (
        !i_internal_dog_enable_in |-> !dog_start && !dog_expire)
        else $error("disabled watchdog acted");
    chk_parity_disable: assert property (i_parity_check_disable_in |-> !ext_par_err)
        else $error("external parity checked while disabled");
    cov_reset_exit: cover property ($fell(o_reset_out));
    cov_sys_halt: cover property (mode_r == EMR_MODE_RUN ##1 mode_r == EMR_MODE_SYS_HALT);
    cov_pwr_wake: cover property (mode_r == EMR_MODE_PWR_DOWN ##1 mode_r == EMR_MODE_RUN);
    cov_dog_reset: cover property (dog_expire);
endmodule : emr_ctrl

/* emr_board_model.sv */
// board and core model: watchdog clock, checked bus, error pins, cold reset
// assumes the bench steers it through command inputs on the core clock
`timescale 1ns/100ps
module emr_board_model
    import emr_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_dog_run,
    input wire logic i_send,
    input wire logic i_bad_par,
    input wire logic [3:0] i_err_req,
    input wire logic i_cold_req,
    output logic o_dog_clk,
    output emr_bus_chk_s o_bus,
    output emr_err_in_s o_err,
    output logic o_cold
);
    logic [1:0] div_r = 2'h0;
    logic [7:0] pat_r = 8'h00;
    logic [31:0] a_w;
    logic [31:0] d_w;
    // watchdog clock at a quarter of the core rate; stands still when not asked
    always @(posedge i_core_clk) begin
        if (i_dog_run) begin
            div_r <= div_r + 2'h1;
        end
    end
    assign o_dog_clk = div_r[1];
    // pattern moves every cycle, so an idle bus never shows a stale word
    assign a_w = {pat_r, ~pat_r, pat_r, 8'h5a};
    assign d_w = {~pat_r, pat_r, 8'hc3, pat_r};
    initial begin
        o_bus = '0;
        o_err = '0;
        o_cold = 1'b0;
    end
    // everything moves on rising edges only
    always @(posedge i_core_clk) begin
        pat_r <= pat_r + 8'h01;
        o_bus.valid <= i_send;
        o_bus.addr <= a_w;
        o_bus.addr_par <= (~^a_w) ^ i_bad_par; // odd parity, broken on request
        o_bus.asi <= pat_r[3:0];
        o_bus.size <= pat_r[5:4];
        o_bus.asi_par <= ~^{pat_r[3:0], pat_r[5:4]};
        o_bus.data <= d_w;
        o_bus.data_par <= ~^d_w;
        o_err <= emr_err_in_s'(i_err_req);
        o_cold <= i_cold_req; // recovery from error halt is ours to give
    end
endmodule : emr_board_model

/* emr_ctrl_tb.sv */
// self-checking bench for the execution-mode controller
// assumes the board model file is compiled before this one
`timescale 1ns/100ps
module emr_ctrl_tb
    import emr_pkg::*;
;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_halt = 1'b0;
    logic i_pdis = 1'b0;
    logic i_dog_en = 1'b1;
    logic [4:0] i_ext_int = 5'h00;
    logic [31:0] i_data_out = 32'h0000_0000;
    logic dog_run = 1'b0;
    logic send = 1'b0;
    logic bad = 1'b0;
    logic [3:0] err_req = 4'h0;
    logic cold_req = 1'b0;
    logic [31:0] o_rdata;
    logic o_data_par_out, o_reset_out, o_unit_freeze, o_unit_run, o_timer_run;
    logic o_error_flag_out, o_availability_flag, o_core_clock_out, o_dog_irq;
    logic [2:0] o_mode;
    logic dog_clk, cold, c0;
    emr_bus_chk_s bus;
    emr_err_in_s err;
    logic [31:0] got;
    int n_errors = 0;
    int compares = 0;
    int last_wait = 0;
    always #5 i_core_clk = ~i_core_clk;
    emr_board_model board (.i_core_clk(i_core_clk), .i_dog_run(dog_run), .i_send(send),
        .i_bad_par(bad), .i_err_req(err_req), .i_cold_req(cold_req), .o_dog_clk(dog_clk),
        .o_bus(bus), .o_err(err), .o_cold(cold));
    emr_ctrl uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cold_reset_in(cold),
        .i_halt_request_in(i_halt), .i_parity_check_disable_in(i_pdis),
        .i_internal_dog_enable_in(i_dog_en), .i_dog_clock_in(dog_clk), .i_ext_int(i_ext_int),
        .i_err(err), .i_bus(bus), .i_data_out(i_data_out), .o_data_par_out(o_data_par_out),
        .o_reset_out(o_reset_out), .o_unit_freeze(o_unit_freeze), .o_unit_run(o_unit_run),
        .o_timer_run(o_timer_run), .o_error_flag_out(o_error_flag_out),
        .o_availability_flag(o_availability_flag), .o_core_clock_out(o_core_clock_out),
        .o_dog_irq(o_dog_irq), .o_mode(o_mode));
    task automatic results();
        if (n_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    // one compare task per width of result
    task automatic cmp1(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp1
    task automatic cmp3(input logic [2:0] g, input logic [2:0] e);
        cmp32({29'h0000_0000, g}, {29'h0000_0000, e});
    endtask : cmp3
    task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp32
    // samples land one step after the edge so the design's updates settle first
    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        got = o_rdata;
    endtask : rd
    // which: 0 run, 1 watchdog pulse, 2 reset output; a spent bound is a mismatch
    task automatic wait_for(input int which, input int lim);
        int n;
        n = 0;
        while (!((which == 0 && o_unit_run === 1'b1) || (which == 1 && o_dog_irq === 1'b1)
                || (which == 2 && o_reset_out === 1'b1))) begin
            @(posedge i_core_clk);
            #1;
            n++;
            if (n > lim) begin
                cmp1(1'b0, 1'b1);
                results();
            end
        end
        last_wait = n;
    endtask : wait_for
    task automatic pulse_err(input logic [3:0] e);
        @(posedge i_core_clk);
        err_req <= e;
        @(posedge i_core_clk);
        err_req <= 4'h0;
        cyc(5);
    endtask : pulse_err
    task automatic bad_par();
        @(posedge i_core_clk);
        send <= 1'b1;
        bad <= 1'b1;
        @(posedge i_core_clk);
        send <= 1'b0;
        bad <= 1'b0;
        cyc(5);
    endtask : bad_par
    task automatic recover();
        @(posedge i_core_clk);
        cold_req <= 1'b1;
        cyc(3);
        cmp1(o_reset_out, 1'b1);
        @(posedge i_core_clk);
        cold_req <= 1'b0;
        wait_for(0, 3000);
    endtask : recover
    // main sequence: power-on, modes, watchdog, errors, parity, soft reset
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        wait_for(0, 3000);
        cmp1(last_wait >= 2048, 1'b1);
        cmp1(o_unit_freeze | ~o_timer_run | o_reset_out, 1'b0);
        rd(ADDR_STATUS);
        cmp32(got, 32'h0000_0101);
        rd(ADDR_CTRL);
        cmp32(got, 32'h0000_0010);
        rd(8'h1c);
        cmp32(got, 32'h0000_0000);
        wr(ADDR_STATUS, 32'h0000_0080);
        cmp1(o_availability_flag, 1'b1);
        for (int i = 0; i < 4; i++) begin
            c0 = o_core_clock_out;
            cyc(1);
            cmp1(o_core_clock_out, ~c0);
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge i_core_clk);
            i_data_out <= 32'h8000_0001 << i;
            cyc(1);
            cmp1(o_data_par_out, ~^(32'h8000_0001 << i));
        end
        @(posedge i_core_clk);
        i_halt <= 1'b1;
        cyc(2);
        cmp3(o_mode, EMR_MODE_SYS_HALT);
        cmp1(o_timer_run | ~o_unit_freeze, 1'b0);
        @(posedge i_core_clk);
        i_halt <= 1'b0;
        cyc(2);
        cmp3(o_mode, EMR_MODE_RUN);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_PWR_DOWN, 32'h0000_0000);
            cmp1(o_unit_freeze & o_timer_run & (o_mode === EMR_MODE_PWR_DOWN), 1'b1);
            @(posedge i_core_clk);
            i_ext_int <= 5'h01 << i;
            cyc(2);
            cmp3(o_mode, EMR_MODE_RUN);
            @(posedge i_core_clk);
            i_ext_int <= 5'h00;
        end
        rd(ADDR_DOG_CNT);
        cmp32(got & 32'h0000_ffff, 32'h0000_ffff);
        @(posedge i_core_clk);
        i_dog_en <= 1'b0;
        wr(ADDR_DOG_LOAD, 32'h0000_0005);
        dog_run <= 1'b1;
        cyc(60);
        rd(ADDR_DOG_CNT);
        cmp32(got & 32'h0000_ffff, 32'h0000_0005);
        // halt must be in force before the enable returns, or a pending tick slips in
        @(posedge i_core_clk);
        i_halt <= 1'b1;
        cyc(2);
        @(posedge i_core_clk);
        i_dog_en <= 1'b1;
        cyc(60);
        rd(ADDR_DOG_CNT);
        cmp32(got & 32'h0000_ffff, 32'h0000_0005);
        @(posedge i_core_clk);
        i_halt <= 1'b0;
        dog_run <= 1'b0;
        cyc(60);
        rd(ADDR_DOG_CNT);
        cmp32(got & 32'h0000_ffff, 32'h0000_0005);
        dog_run <= 1'b1;
        wait_for(1, 200);
        cyc(1);
        cmp1(o_dog_irq, 1'b0);
        rd(ADDR_DOG_CNT);
        cmp32(got & 32'h0100_ffff, 32'h0100_0000);
        wr(ADDR_DOG_ACK, 32'h0000_0000);
        cyc(1200);
        cmp1(o_reset_out, 1'b0);
        wr(ADDR_DOG_LOAD, 32'h0000_0002);
        wait_for(1, 200);
        wait_for(2, 1500);
        dog_run <= 1'b0;
        wait_for(0, 3000);
        rd(ADDR_STATUS);
        cmp32(got & 32'h0000_0007, 32'h0000_0003);
        pulse_err(4'h8);
        cmp3(o_mode, EMR_MODE_ERR_HALT);
        cmp1(o_error_flag_out, 1'b1);
        rd(ADDR_STATUS);
        cmp32(got & 32'h0000_0778, 32'h0000_0408);
        wr(ADDR_SOFT_RST, 32'h0000_0000);
        cyc(2);
        cmp3(o_mode, EMR_MODE_ERR_HALT);
        recover();
        rd(ADDR_STATUS);
        cmp32(got & 32'h0000_077f, 32'h0000_0101);
        wr(ADDR_CTRL, 32'h0000_0012);
        pulse_err(4'h4);
        cmp1(o_error_flag_out | ~o_unit_run, 1'b0);
        wr(ADDR_STATUS, 32'h0000_0078);
        wr(ADDR_CTRL, 32'h0000_0000);
        pulse_err(4'h4);
        cmp1(o_error_flag_out & o_unit_run, 1'b1);
        rd(ADDR_STATUS);
        cmp32(got & 32'h0000_0078, 32'h0000_0010);
        wr(ADDR_STATUS, 32'h0000_0078);
        cyc(2);
        cmp1(o_error_flag_out, 1'b0);
        pulse_err(4'h1);
        cmp3(o_mode, EMR_MODE_ERR_HALT);
        recover();
        @(posedge i_core_clk);
        i_pdis <= 1'b1;
        bad_par();
        cmp3(o_mode, EMR_MODE_RUN);
        @(posedge i_core_clk);
        i_pdis <= 1'b0;
        send <= 1'b1;
        cyc(8);
        send <= 1'b0;
        cmp3(o_mode, EMR_MODE_RUN);
        bad_par();
        cmp3(o_mode, EMR_MODE_ERR_HALT);
        recover();
        wr(ADDR_CTRL, 32'h0000_0030);
        bad_par();
        cmp1(o_reset_out, 1'b1);
        wr(ADDR_STATUS, 32'h0000_0078);
        wait_for(0, 3000);
        rd(ADDR_STATUS);
        cmp32(got & 32'h0000_0007, 32'h0000_0004);
        wr(ADDR_SOFT_RST, 32'h0000_0000);
        cmp1(o_reset_out & (o_mode === EMR_MODE_RESET), 1'b1);
        cyc(1000);
        wr(ADDR_SOFT_RST, 32'h0000_0000);
        wait_for(0, 3000);
        cmp1(last_wait >= 2048, 1'b1);
        rd(ADDR_STATUS);
        cmp32(got & 32'h0000_0007, 32'h0000_0002);
        results();
    end
endmodule : emr_ctrl_tb
